// File: hdl/tspd_pkg.sv
package tspd_pkg;

   // width of the strap field that selects the test configuration
   localparam int unsigned CODE_W = 3;

   // captured strap codes on the low test points
   localparam logic [2:0] CODE_NO_SWITCHING = 3'h0;
   localparam logic [2:0] CODE_CLOCK_DEBUG  = 3'h2;

   // number of test-point pins
   localparam int unsigned TP_W = 8;

   // values of the pin drivers: reset not driven and low, or all driven
   localparam logic [7:0] TP_LEVEL_RESET  = 8'h00;
   localparam logic [7:0] TP_ENABLE_RESET = 8'h00;
   localparam logic [7:0] TP_ENABLE_ALL   = 8'hff;

   // static levels in clock-debug mode: bits 3,5,6 high, bit 4 low
   localparam logic [7:0] TP_STATIC_LEVELS = 8'h68;

   // bit positions of the clock probes
   localparam int unsigned BIT_FAST = 0;
   localparam int unsigned BIT_HALF = 1;
   localparam int unsigned BIT_VAR  = 2;
   localparam int unsigned BIT_SLOW = 7;

   // probe counter: fast = bit 0, half = bit 1, slow (1/8 of fast) = bit 3
   localparam int unsigned PROBE_CNT_W = 4;
   localparam int unsigned PROBE_FAST  = 0;
   localparam int unsigned PROBE_HALF  = 1;
   localparam int unsigned PROBE_SLOW  = 3;
   localparam logic [3:0]  PROBE_CNT_RESET = 4'h0;

   // default half period, in clock cycles, of the variable probe clock
   localparam int unsigned VAR_HALF_DEFAULT = 2;

   // reset values of the variable-rate divider
   localparam logic [7:0] VAR_CNT_RESET = 8'h00;
   localparam logic       VAR_CLK_RESET = 1'b0;

   // port states after reset release
   typedef enum logic [0:0] {
      TSPD_HELD,
      TSPD_RUN
   } tspd_state_t;

   // drive pattern for the test-point pins
   typedef struct packed {
      logic [7:0] level;
      logic [7:0] enable;
   } tspd_drive_t;

endpackage

// File: hdl/tspd_port.sv
`timescale 1ns/1ps
`default_nettype none

module tspd_port #(
   parameter int unsigned VAR_HALF = tspd_pkg::VAR_HALF_DEFAULT
) (
   input  wire logic       CLK,
   input  wire logic       RST_N,
   input  wire logic [7:0] DEBUG_TEST_POINTS_IN,
   output var  logic [7:0] DEBUG_TEST_POINTS_OUT,
   output var  logic [7:0] DEBUG_TEST_POINTS_OE,
   output var  logic [2:0] TEST_CONFIG
);

   // refuse a variable probe divider the counter cannot serve: it
   // counts in eight bits, and a zero half period wraps its compare value to 255
   if (VAR_HALF < 1 || VAR_HALF > 255) begin : g_bad_var_half
      $error("tspd_port: VAR_HALF must lie in 1..255");
   end

   // the pin group and the strap field are fixed in width
   if (tspd_pkg::TP_W != 8) begin : g_bad_pin_count
      $error("tspd_port: eight test-point pins expected");
   end
   if (tspd_pkg::CODE_W != 3) begin : g_bad_code_width
      $error("tspd_port: three-bit strap code expected");
   end

   // the probes are scaled copies of the core clock: the fast probe
   // runs at half its rate, the half probe at a quarter and the slow
   // probe at a sixteenth, which keeps the 8:4:1 ratio of the fixed
   // probes; true rates need a faster clock than this block has, so
   // a bench instrument must scale its readings by the same factor
   // (the variable probe flips once every VAR_HALF edges)

   // true for the one code that turns the pins into clock probes
   function automatic logic is_clock_debug(
      input logic [2:0] code
   );
      return code == tspd_pkg::CODE_CLOCK_DEBUG;
   endfunction

   // strap field: the low three pins; the upper five are never read
   function automatic logic [2:0] strap_code(
      input logic [7:0] pins
   );
      return pins[2:0];
   endfunction

   // levels of the clock-debug pattern: fixed levels first, then the
   // four probe clocks laid over their own bit positions
   function automatic logic [7:0] probe_pattern(
      input logic [3:0] cnt,
      input logic       var_level
   );
      logic [7:0] lv;
      lv = tspd_pkg::TP_STATIC_LEVELS;
      lv[tspd_pkg::BIT_FAST] = cnt[tspd_pkg::PROBE_FAST];
      lv[tspd_pkg::BIT_HALF] = cnt[tspd_pkg::PROBE_HALF];
      lv[tspd_pkg::BIT_VAR]  = var_level;
      lv[tspd_pkg::BIT_SLOW] = cnt[tspd_pkg::PROBE_SLOW];
      return lv;
   endfunction

   // pattern that leaves every pin to its board resistor
   function automatic tspd_pkg::tspd_drive_t quiet_drive();
      tspd_pkg::tspd_drive_t d;
      d.level  = tspd_pkg::TP_LEVEL_RESET;
      d.enable = tspd_pkg::TP_ENABLE_RESET;
      return d;
   endfunction

   // port state, drive pattern, strap capture and the probe dividers
   tspd_pkg::tspd_state_t state;
   tspd_pkg::tspd_state_t next_state;
   tspd_pkg::tspd_drive_t next_drive;
   logic [2:0]            next_config;
   logic                  strap_window;
   logic [3:0]            probe_cnt;
   logic [3:0]            next_probe_cnt;
   logic [7:0]            var_cnt;
   logic [7:0]            next_var_cnt;
   logic                  var_clk;
   logic                  next_var_clk;

   // the port runs from the first edge with reset released
   always_comb begin
      next_state = tspd_pkg::TSPD_HELD;
      if (RST_N) begin
         next_state = tspd_pkg::TSPD_RUN;
      end
   end

   // hold the pins released while reset is low, then run
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         state <= tspd_pkg::TSPD_HELD;
      end else begin
         state <= next_state;
      end
   end

   // the strap is open only on the first edge after reset release,
   // while the port is still held and the pins are undriven
   assign strap_window = (state == tspd_pkg::TSPD_HELD);

   // strap capture: the low pins are taken inside the strap window,
   // every later edge keeps the code, so moving the straps after
   // release has no effect until the next reset
   always_comb begin
      next_config = TEST_CONFIG;
      if (strap_window) begin
         next_config = strap_code(DEBUG_TEST_POINTS_IN);
      end
   end

   // captured test configuration, cleared while reset is low so a
   // fresh release always starts from the quiet default
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         TEST_CONFIG <= tspd_pkg::CODE_NO_SWITCHING;
      end else begin
         TEST_CONFIG <= next_config;
      end
   end

   // next count of the fixed-ratio divider; it wraps at sixteen,
   // which is the period of the slow probe
   always_comb begin
      next_probe_cnt = probe_cnt + 4'h1;
   end

   // free-running divider for the fixed-ratio probe clocks; it also
   // runs in quiet mode, but nothing leaves the block then
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         probe_cnt <= tspd_pkg::PROBE_CNT_RESET;
      end else begin
         probe_cnt <= next_probe_cnt;
      end
   end

   // next state of the variable-rate divider: the count wraps after
   // VAR_HALF edges and the probe level flips at the wrap, giving a
   // period of twice VAR_HALF edges
   always_comb begin
      next_var_cnt = var_cnt + 8'h01;
      next_var_clk = var_clk;
      if (var_cnt == 8'(VAR_HALF - 1)) begin
         next_var_cnt = tspd_pkg::VAR_CNT_RESET;
         next_var_clk = ~var_clk;
      end
   end

   // count of the variable-rate divider
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         var_cnt <= tspd_pkg::VAR_CNT_RESET;
      end else begin
         var_cnt <= next_var_cnt;
      end
   end

   // level of the variable-rate probe clock
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         var_clk <= tspd_pkg::VAR_CLK_RESET;
      end else begin
         var_clk <= next_var_clk;
      end
   end

   // choose the pin pattern from the captured code; anything but the
   // clock-debug code, the default included, leaves the pins quiet
   always_comb begin
      next_drive = quiet_drive();
      unique case (state)
         tspd_pkg::TSPD_HELD: begin
            next_drive = quiet_drive();
         end
         tspd_pkg::TSPD_RUN: begin
            if (RST_N && is_clock_debug(TEST_CONFIG)) begin
               next_drive.level  = probe_pattern(probe_cnt, var_clk);
               next_drive.enable = tspd_pkg::TP_ENABLE_ALL;
            end else begin
               next_drive = quiet_drive();
            end
         end
      endcase
   end

   // registered pin levels; a released pin is held low so the level
   // only moves while the pin is driven
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         DEBUG_TEST_POINTS_OUT <= tspd_pkg::TP_LEVEL_RESET;
      end else begin
         DEBUG_TEST_POINTS_OUT <= next_drive.level;
      end
   end

   // registered pin enables; released on the first edge of reset so
   // the board straps are never fought during the strap window
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         DEBUG_TEST_POINTS_OE <= tspd_pkg::TP_ENABLE_RESET;
      end else begin
         DEBUG_TEST_POINTS_OE <= next_drive.enable;
      end
   end

endmodule

`default_nettype wire

// File: dv/tspd_props.sv
`timescale 1ns/1ps
`default_nettype none
module tspd_props (
   input wire logic       CLK,
   input wire logic       RST_N,
   input wire logic [7:0] DEBUG_TEST_POINTS_IN,
   input wire logic [7:0] DEBUG_TEST_POINTS_OUT,
   input wire logic [7:0] DEBUG_TEST_POINTS_OE,
   input wire logic [2:0] TEST_CONFIG
);
   wire logic [7:0] oe = DEBUG_TEST_POINTS_OE;
   wire logic [7:0] q = DEBUG_TEST_POINTS_OUT;
   wire logic [2:0] c = TEST_CONFIG;
   // outputs are unknown until the first reset edge has passed
   bit started = 1'b0;
   always_ff @(posedge CLK) started <= started | !RST_N;
   default clocking @(posedge CLK); endclocking
   // pin drive follows reset and the captured code
   a_reset_quiet: assert property (started && !$past(RST_N)
      |-> oe == 8'h00)
      else $error("driven in reset");
   a_quiet_code: assert property ($past(RST_N) && $past(c) != 3'h2
      |-> oe == 8'h00) else $error("quiet code drives");
   a_debug_pins: assert property ($past(RST_N) && $past(c) == 3'h2
      |-> oe == 8'hff && q[6:3] == 4'hd) else $error("debug levels");
   a_strap_take: assert property ($rose(RST_N) |=>
      c == $past(DEBUG_TEST_POINTS_IN[2:0]))
      else $error("strap not taken");
   a_config_hold: assert property (RST_N && $past(RST_N)
      && $past(RST_N, 2) |-> $stable(c)) else $error("code moved");
   a_probe_rate: assert property (oe == 8'hff && $past(oe) == 8'hff
      |-> q[0] != $past(q[0]) && q[1] == ($past(q[1]) ^ $past(q[0])))
      else $error("probe rate");
endmodule
`default_nettype wire

// File: dv/tspd_board.sv
`timescale 1ns/1ps
`default_nettype none
module tspd_board (
   input  wire logic [7:0] out,
   input  wire logic [7:0] oe,
   input  wire logic [2:0] strap,
   output wire logic [7:0] pin
);
   // pulldowns on all pins, jumpered pullups on the low three only
   assign pin = (oe & out) | (~oe & {5'h00, strap});
endmodule
`default_nettype wire

// File: dv/test_tspd_port.sv
`timescale 1ns/1ps
`default_nettype none
module test_tspd_port;
   logic [2:0] strap = 3'h0;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   wire logic [7:0] pin, out, oe;
   wire logic [2:0] cfg;
   int mismatches = 0;
   int checks_done = 0;
   // toggles per 32 cycles in debug mode, divider half period 4
   localparam logic [7:0] rate [8] = '{8'h20, 8'h10, 8'h08, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h04};
   always #25 clk = ~clk;
   tspd_board i_board (.out(out), .oe(oe), .strap(strap), .pin(pin));
   tspd_port #(.VAR_HALF(4)) i_dut (.CLK(clk), .RST_N(rst_n),
      .DEBUG_TEST_POINTS_IN(pin), .DEBUG_TEST_POINTS_OUT(out),
      .DEBUG_TEST_POINTS_OE(oe), .TEST_CONFIG(cfg));
   task automatic check(string what, logic [7:0] exp, logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // reset with one strap code, move the strap, judge the pins
   task automatic strap_run(logic [2:0] code);
      logic [7:0] t;
      logic [7:0] n [8];
      logic       dbg;
      dbg = (code == 3'h2);
      rst_n <= 1'b0;
      strap <= code;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      #1 check("oe held", 8'h00, oe);
      @(posedge clk);
      strap <= ~code;
      @(posedge clk);
      #1 check("config", {5'h00, code}, {5'h00, cfg});
      check("oe", dbg ? 8'hff : 8'h00, oe);
      check("levels", dbg ? 8'h68 : 8'h00, out & 8'h78);
      n = '{default: 8'h00};
      for (int i = 0; i < 32; i++) begin
         t = out;
         @(posedge clk);
         #1 foreach (n[b]) n[b] += {7'h00, t[b] ^ out[b]};
      end
      foreach (n[j]) check("toggles", dbg ? rate[j] : 8'h00, n[j]);
      check("config kept", {5'h00, code}, {5'h00, cfg});
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // every strap code in turn, each behind a fresh reset
   initial begin
      for (int c = 0; c < 8; c++)
         strap_run(3'(c));
      results();
   end
endmodule
bind tspd_port tspd_props i_props (.CLK(CLK), .RST_N(RST_N),
   .DEBUG_TEST_POINTS_IN(DEBUG_TEST_POINTS_IN),
   .DEBUG_TEST_POINTS_OUT(DEBUG_TEST_POINTS_OUT),
   .DEBUG_TEST_POINTS_OE(DEBUG_TEST_POINTS_OE),
   .TEST_CONFIG(TEST_CONFIG));
`default_nettype wire
